// ==== inc/sysctl_pkg.sv ====
// constants for the system control register bank
package sysctl_pkg;
   // ----------------------------------------
   // host i/o ports
   // ----------------------------------------
   localparam logic [15:0] LOCK_PORT = 16'h03C3;
   localparam logic [15:0] INDEX_PORT = 16'h03C4;
   localparam logic [15:0] DATA_PORT = 16'h03C5;
   localparam logic [2:0] UNLOCK_KEY = 3'h2;
   // ----------------------------------------
   // register indices
   // ----------------------------------------
   localparam logic [7:0] IDX_START0 = 8'h10;
   localparam logic [7:0] IDX_START1 = 8'h11;
   localparam logic [7:0] IDX_START2 = 8'h12;
   localparam logic [7:0] IDX_START3 = 8'h13;
   localparam logic [7:0] IDX_MISC = 8'h15;
   localparam logic [7:0] IDX_STATUS = 8'h16;
   localparam logic [7:0] IDX_CMD1 = 8'h17;
   localparam logic [7:0] IDX_CMD2 = 8'h18;
   localparam logic [7:0] IDX_IRQEM = 8'h19;
   localparam logic [7:0] IDX_IRQST = 8'h1A;
   // ----------------------------------------
   // reset values and writable bits
   // ----------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] WM_ALL = 8'hFF;
   localparam logic [7:0] WM_MISC = 8'hB8;
   localparam logic [7:0] WM_CMD1 = 8'hBF;
   localparam logic [7:0] WM_IRQEM = 8'h77;
   localparam logic [7:0] ZERO8 = 8'h00;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int B_BI_ENDIAN = 0;
   localparam int B_BURST_RD = 7;
   localparam int B_SOFT_ABORT = 5;
   localparam int B_ENG_ABORT = 4;
   localparam int B_SIDLOCK = 3;
   localparam int B_MEM_BLK = 7;
   localparam int B_BURST = 5;
   localparam int B_SWAP_MODE = 4;
   localparam int B_ZSEL = 2;
   localparam int B_MAPPED = 1;
   localparam int B_LAT_DIS = 0;
   localparam int B_PINF = 7;
   localparam int B_CLKRUN_EN = 6;
   localparam int B_AP_MODE = 5;
   localparam int B_MODE = 3;
   localparam int B_DATA_PATH = 2;
   localparam int B_ROTATE = 1;
   localparam int B_LINEAR = 0;
   localparam int B_IEN = 4;
   localparam int B_IMSK = 0;
   // ----------------------------------------
   // encodings
   // ----------------------------------------
   localparam logic [1:0] ZSEL_LOW = 2'h1;
   localparam logic [1:0] ZSEL_HIGH = 2'h2;
   localparam logic [1:0] MODE_STD = 2'h0;
   localparam logic [3:0] FIFO_DEPTH = 4'h8;
   localparam logic [2:0] FIFO_EDGE = 3'h7;
   localparam logic [1:0] WIN_ALL = 2'h0;
   localparam logic [1:0] WIN_A = 2'h1;
   localparam logic [1:0] WIN_B0 = 2'h2;
   localparam logic [19:0] A_A0000 = 20'hA0000;
   localparam logic [19:0] A_AFFFF = 20'hAFFFF;
   localparam logic [19:0] A_B0000 = 20'hB0000;
   localparam logic [19:0] A_B7000 = 20'hB7000;
   localparam logic [19:0] A_B8000 = 20'hB8000;
   localparam logic [19:0] A_BFFFF = 20'hBFFFF;
endpackage : sysctl_pkg

// ==== hw/cfg_byte_reg.sv ====
// one host-writable control byte with a mask of writable bits
`timescale 1ns/1ps
module cfg_byte_reg #(
   parameter logic [7:0] RST = 8'h00,
   parameter logic [7:0] WMASK = 8'hFF
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] q
);
   // masked bits keep their reset value, so reserved bits stay zero
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         q <= RST;
      end else if (we) begin
         q <= (q & ~WMASK) | (wdata & WMASK);
      end
   end
endmodule : cfg_byte_reg

// ==== hw/sync2.sv ====
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         // idle high, so an active-low pin shows no false level
         meta_r <= '1;
         q <= '1;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : sync2

// ==== hw/system_control_register_bank.sv ====
// system control register bank behind the indexed host i/o ports
//
// Summary of operation
// - write key 010 to lock port unlocks
// - index/data pair decodes registers by index
// - bank runs only on the system clock
// - four bytes form master start address
// - start byte bit 0 selects bi-endian
// - burst read needs both enable bits
// - soft abort needs engine abort enable
// - three frame status bits per display
// - fifo not-empty and engine busy flags
// - free entry code, 111 empty or full
// - block host memory while engine busy
// - swap select: bytes or half words
// - depth data select picks word halves
// - aperture select gates mapped register access
// - shared pin: clock-run input or indicator_a
// - aperture mode only in linear mode
// - access mode sets bus width, wrap
// - data path bit when upper mode clear
// - banked window chosen by misc bits
// - irq raised when enabled and unmasked
// - read-only pending interrupt status
`timescale 1ns/1ps
module system_control_register_bank #(
   parameter logic DEVICE_SELECT = 1'b0 // arbitrary device code
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [15:0] IO_ADDR,
   input wire logic IO_WR,
   input wire logic IO_RD,
   input wire logic [7:0] IO_WDATA,
   output logic [7:0] IO_RDATA,
   output logic IO_RVALID,
   input wire logic [2:0] FRAME_STATUS,
   input wire logic [3:0] ENGINE_FIFO_USED,
   input wire logic ENGINE_BUSY,
   input wire logic [3:0] IRQ_SOURCES,
   input wire logic [19:0] HOST_MEM_ADDR,
   input wire logic [1:0] GFX_MEM_MAP,
   input wire logic CLKRUN_N_IN,
   output logic INDICATOR_A_OUT,
   output logic INDICATOR_A_OE,
   output logic CLKRUN_REQ,
   output logic [31:0] MASTER_START_ADDR,
   output logic BI_ENDIAN,
   output logic BURST_READ_EN,
   output logic BURST_EN,
   output logic ENGINE_ABORT_EN,
   output logic SOFT_ABORT_EN,
   output logic SUBSYS_ID_LOCK,
   output logic HOST_MEM_BLOCK,
   output logic ENDIAN_SWAP_MODE,
   output logic [1:0] ZBUF_HALF_EN,
   output logic MMIO_EN,
   output logic LATENCY_TIMER_DISABLE,
   output logic LINEAR_EN,
   output logic LEGACY_HIT,
   output logic WRAP_256K,
   output logic BUS_64BIT,
   output logic ROTATE_BLT_EN,
   output logic IRQ
);
   // ----------------------------------------
   // host port decode
   // ----------------------------------------
   logic unlock_r;
   logic [7:0] index_r;
   logic wr_data;
   logic [7:0] start0;
   logic [7:0] start1;
   logic [7:0] start2;
   logic [7:0] start3;
   logic [7:0] misc;
   logic [7:0] cmd1;
   logic [7:0] cmd2;
   logic [7:0] irqem;
   logic [7:0] status_byte;
   logic [7:0] irqst_byte;
   logic [7:0] rdata_nxt;
   logic [2:0] free_code;
   logic fifo_not_empty;
   logic [3:0] free_cnt;
   logic clkrun_n_s;
   logic legacy_nxt;

   // a write to the lock port whose bits 7:5 are not the key locks again
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         unlock_r <= 1'b0;
      end else if (IO_WR && IO_ADDR == sysctl_pkg::LOCK_PORT) begin
         unlock_r <= (IO_WDATA[7:5] == sysctl_pkg::UNLOCK_KEY);
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         index_r <= sysctl_pkg::ZERO8;
      end else if (IO_WR && IO_ADDR == sysctl_pkg::INDEX_PORT) begin
         index_r <= IO_WDATA;
      end
   end

   // locked bank ignores data port writes
   assign wr_data = IO_WR && unlock_r &&
      IO_ADDR == sysctl_pkg::DATA_PORT;

   // ----------------------------------------
   // writable registers
   // ----------------------------------------
   // all clocked from CLK alone, no memory or video clock
   cfg_byte_reg #(.RST(sysctl_pkg::RST_ZERO), .WMASK(sysctl_pkg::WM_ALL))
   u_start0 (.CLK(CLK), .RSTN(RSTN),
      .we(wr_data && index_r == sysctl_pkg::IDX_START0),
      .wdata(IO_WDATA), .q(start0));
   cfg_byte_reg #(.RST(sysctl_pkg::RST_ZERO), .WMASK(sysctl_pkg::WM_ALL))
   u_start1 (.CLK(CLK), .RSTN(RSTN),
      .we(wr_data && index_r == sysctl_pkg::IDX_START1),
      .wdata(IO_WDATA), .q(start1));
   cfg_byte_reg #(.RST(sysctl_pkg::RST_ZERO), .WMASK(sysctl_pkg::WM_ALL))
   u_start2 (.CLK(CLK), .RSTN(RSTN),
      .we(wr_data && index_r == sysctl_pkg::IDX_START2),
      .wdata(IO_WDATA), .q(start2));
   cfg_byte_reg #(.RST(sysctl_pkg::RST_ZERO), .WMASK(sysctl_pkg::WM_ALL))
   u_start3 (.CLK(CLK), .RSTN(RSTN),
      .we(wr_data && index_r == sysctl_pkg::IDX_START3),
      .wdata(IO_WDATA), .q(start3));
   // reserved bits masked off so they read zero
   cfg_byte_reg #(.RST(sysctl_pkg::RST_ZERO), .WMASK(sysctl_pkg::WM_MISC))
   u_misc (.CLK(CLK), .RSTN(RSTN),
      .we(wr_data && index_r == sysctl_pkg::IDX_MISC),
      .wdata(IO_WDATA), .q(misc));
   cfg_byte_reg #(.RST(sysctl_pkg::RST_ZERO), .WMASK(sysctl_pkg::WM_CMD1))
   u_cmd1 (.CLK(CLK), .RSTN(RSTN),
      .we(wr_data && index_r == sysctl_pkg::IDX_CMD1),
      .wdata(IO_WDATA), .q(cmd1));
   cfg_byte_reg #(.RST(sysctl_pkg::RST_ZERO), .WMASK(sysctl_pkg::WM_ALL))
   u_cmd2 (.CLK(CLK), .RSTN(RSTN),
      .we(wr_data && index_r == sysctl_pkg::IDX_CMD2),
      .wdata(IO_WDATA), .q(cmd2));
   cfg_byte_reg #(.RST(sysctl_pkg::RST_ZERO), .WMASK(sysctl_pkg::WM_IRQEM))
   u_irqem (.CLK(CLK), .RSTN(RSTN),
      .we(wr_data && index_r == sysctl_pkg::IDX_IRQEM),
      .wdata(IO_WDATA), .q(irqem));

   // ----------------------------------------
   // status bytes
   // ----------------------------------------
   always_comb begin
      free_cnt = sysctl_pkg::FIFO_DEPTH - ENGINE_FIFO_USED;
      fifo_not_empty = (ENGINE_FIFO_USED != 4'h0);
      // empty and full both show 111, told apart by the not-empty flag
      if (free_cnt == 4'h0 || free_cnt >= sysctl_pkg::FIFO_DEPTH) begin
         free_code = sysctl_pkg::FIFO_EDGE;
      end else begin
         free_code = 3'(free_cnt - 4'h1);
      end
   end

   assign status_byte = {FRAME_STATUS, fifo_not_empty,
      ENGINE_BUSY, free_code};
   assign irqst_byte = {3'h0, IRQ_SOURCES[3], 1'b0,
      IRQ_SOURCES[2:0]};

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb begin
      rdata_nxt = sysctl_pkg::ZERO8;
      if (IO_ADDR == sysctl_pkg::LOCK_PORT) begin
         rdata_nxt = {unlock_r ? sysctl_pkg::UNLOCK_KEY : 3'h0, 5'h00};
      end else if (IO_ADDR == sysctl_pkg::INDEX_PORT) begin
         rdata_nxt = index_r;
      end else if (IO_ADDR != sysctl_pkg::DATA_PORT || !unlock_r) begin
         rdata_nxt = sysctl_pkg::ZERO8;
      end else if (index_r == sysctl_pkg::IDX_START0) begin
         rdata_nxt = start0;
      end else if (index_r == sysctl_pkg::IDX_START1) begin
         rdata_nxt = start1;
      end else if (index_r == sysctl_pkg::IDX_START2) begin
         rdata_nxt = start2;
      end else if (index_r == sysctl_pkg::IDX_START3) begin
         rdata_nxt = start3;
      end else if (index_r == sysctl_pkg::IDX_MISC) begin
         rdata_nxt = misc | {7'h00, DEVICE_SELECT};
      end else if (index_r == sysctl_pkg::IDX_STATUS) begin
         rdata_nxt = status_byte;
      end else if (index_r == sysctl_pkg::IDX_CMD1) begin
         rdata_nxt = cmd1;
      end else if (index_r == sysctl_pkg::IDX_CMD2) begin
         rdata_nxt = cmd2;
      end else if (index_r == sysctl_pkg::IDX_IRQEM) begin
         rdata_nxt = irqem;
      end else if (index_r == sysctl_pkg::IDX_IRQST) begin
         rdata_nxt = irqst_byte;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         IO_RDATA <= sysctl_pkg::ZERO8;
         IO_RVALID <= 1'b0;
      end else begin
         IO_RVALID <= IO_RD;
         if (IO_RD) begin
            IO_RDATA <= rdata_nxt;
         end
      end
   end

   // ----------------------------------------
   // banked window decode
   // ----------------------------------------
   always_comb begin
      legacy_nxt = 1'b0;
      if (cmd2[sysctl_pkg::B_LINEAR]) begin
         // dual aperture keeps only the a-segment alive
         legacy_nxt = !cmd2[sysctl_pkg::B_AP_MODE] &&
            HOST_MEM_ADDR >= sysctl_pkg::A_A0000 &&
            HOST_MEM_ADDR <= sysctl_pkg::A_AFFFF;
      end else if (GFX_MEM_MAP == sysctl_pkg::WIN_ALL) begin
         legacy_nxt = HOST_MEM_ADDR >= sysctl_pkg::A_A0000 &&
            HOST_MEM_ADDR <= sysctl_pkg::A_BFFFF;
      end else if (GFX_MEM_MAP == sysctl_pkg::WIN_A) begin
         legacy_nxt = HOST_MEM_ADDR >= sysctl_pkg::A_A0000 &&
            HOST_MEM_ADDR <= sysctl_pkg::A_AFFFF;
      end else if (GFX_MEM_MAP == sysctl_pkg::WIN_B0) begin
         legacy_nxt = HOST_MEM_ADDR >= sysctl_pkg::A_B0000 &&
            HOST_MEM_ADDR <= sysctl_pkg::A_B7000;
      end else begin
         legacy_nxt = HOST_MEM_ADDR >= sysctl_pkg::A_B8000 &&
            HOST_MEM_ADDR <= sysctl_pkg::A_BFFFF;
      end
   end

   // ----------------------------------------
   // clock-run pin
   // ----------------------------------------
   sync2 #(.W(1)) u_clkrun_sync (.CLK(CLK), .RSTN(RSTN),
      .d(CLKRUN_N_IN), .q(clkrun_n_s));

   // ----------------------------------------
   // control outputs, registered
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         MASTER_START_ADDR <= 32'h0000_0000;
         BI_ENDIAN <= 1'b0;
         BURST_READ_EN <= 1'b0;
         BURST_EN <= 1'b0;
         ENGINE_ABORT_EN <= 1'b0;
         SOFT_ABORT_EN <= 1'b0;
         SUBSYS_ID_LOCK <= 1'b0;
         HOST_MEM_BLOCK <= 1'b0;
         ENDIAN_SWAP_MODE <= 1'b0;
         ZBUF_HALF_EN <= 2'h3;
         MMIO_EN <= 1'b0;
         LATENCY_TIMER_DISABLE <= 1'b0;
         LINEAR_EN <= 1'b0;
         LEGACY_HIT <= 1'b0;
         WRAP_256K <= 1'b1;
         BUS_64BIT <= 1'b0;
         ROTATE_BLT_EN <= 1'b0;
      end else begin
         // bit 0 of the address is always even
         MASTER_START_ADDR <= {start3, start2, start1,
            start0[7:1], 1'b0};
         BI_ENDIAN <= start0[sysctl_pkg::B_BI_ENDIAN];
         BURST_READ_EN <= misc[sysctl_pkg::B_BURST_RD] &&
            cmd1[sysctl_pkg::B_BURST];
         BURST_EN <= cmd1[sysctl_pkg::B_BURST];
         ENGINE_ABORT_EN <= misc[sysctl_pkg::B_ENG_ABORT];
         SOFT_ABORT_EN <= misc[sysctl_pkg::B_SOFT_ABORT] &&
            misc[sysctl_pkg::B_ENG_ABORT];
         SUBSYS_ID_LOCK <= misc[sysctl_pkg::B_SIDLOCK];
         HOST_MEM_BLOCK <= cmd1[sysctl_pkg::B_MEM_BLK] && ENGINE_BUSY;
         ENDIAN_SWAP_MODE <= cmd1[sysctl_pkg::B_SWAP_MODE];
         if (cmd1[sysctl_pkg::B_ZSEL +: 2] == sysctl_pkg::ZSEL_LOW) begin
            ZBUF_HALF_EN <= 2'h1;
         end else if (cmd1[sysctl_pkg::B_ZSEL +: 2] ==
               sysctl_pkg::ZSEL_HIGH) begin
            ZBUF_HALF_EN <= 2'h2;
         end else begin
            ZBUF_HALF_EN <= 2'h3;
         end
         // mapped registers reachable only via the mapped aperture;
         // order of setting is software's job
         MMIO_EN <= cmd1[sysctl_pkg::B_MAPPED] &&
            cmd2[sysctl_pkg::B_LINEAR];
         LATENCY_TIMER_DISABLE <= cmd1[sysctl_pkg::B_LAT_DIS];
         LINEAR_EN <= cmd2[sysctl_pkg::B_LINEAR];
         LEGACY_HIT <= legacy_nxt;
         WRAP_256K <= cmd2[sysctl_pkg::B_MODE +: 2] ==
            sysctl_pkg::MODE_STD;
         // direct path only counts while the upper mode bit is clear
         BUS_64BIT <= cmd2[sysctl_pkg::B_MODE + 1] ||
            cmd2[sysctl_pkg::B_DATA_PATH];
         ROTATE_BLT_EN <= cmd2[sysctl_pkg::B_ROTATE];
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         INDICATOR_A_OUT <= 1'b0;
         INDICATOR_A_OE <= 1'b0;
         CLKRUN_REQ <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         INDICATOR_A_OE <= cmd2[sysctl_pkg::B_PINF];
         INDICATOR_A_OUT <= ENGINE_BUSY;
         CLKRUN_REQ <= cmd2[sysctl_pkg::B_CLKRUN_EN] &&
            !cmd2[sysctl_pkg::B_PINF] && !clkrun_n_s;
         IRQ <= |(IRQ_SOURCES[2:0] & irqem[sysctl_pkg::B_IEN +: 3] &
            ~irqem[sysctl_pkg::B_IMSK +: 3]);
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   locked_write_a: assert property (
      (IO_WR && !unlock_r && IO_ADDR == sysctl_pkg::DATA_PORT)
      |=> $stable(cmd1) && $stable(cmd2) && $stable(irqem))
      else $error("locked bank accepted a write");
   unlock_key_a: assert property (
      (IO_WR && IO_ADDR == sysctl_pkg::LOCK_PORT && IO_WDATA[7:5] == 3'h2)
      |=> unlock_r)
      else $error("unlock key did not unlock");
   burst_gate_a: assert property (
      BURST_READ_EN |-> $past(misc[7]) && $past(cmd1[5]))
      else $error("burst read enabled without both bits");
   abort_dep_a: assert property (SOFT_ABORT_EN |-> ENGINE_ABORT_EN)
      else $error("soft abort without engine abort");
   fifo_empty_a: assert property (
      (ENGINE_FIFO_USED == 4'h0) |-> !status_byte[4] && &status_byte[2:0])
      else $error("empty fifo code wrong");
   fifo_full_a: assert property (
      (ENGINE_FIFO_USED == 4'h8) |-> status_byte[4] && &status_byte[2:0])
      else $error("full fifo code wrong");
   mem_block_a: assert property (
      (cmd1[7] && ENGINE_BUSY) |=> HOST_MEM_BLOCK)
      else $error("host memory not blocked while busy");
   read_answer_a: assert property (
      IO_RVALID == $past(IO_RD))
      else $error("read answer missing or stretched");
   irq_gate_a: assert property (
      IRQ |-> $past(|(IRQ_SOURCES[2:0] & irqem[6:4] & ~irqem[2:0])))
      else $error("interrupt raised while masked or disabled");
   reserved_zero_a: assert property (
      misc[6] == 1'b0 && misc[2:1] == 2'h0 && cmd1[6] == 1'b0 &&
      irqem[7] == 1'b0 && irqem[3] == 1'b0)
      else $error("reserved bit set");
   start_addr_a: assert property (
      (wr_data && index_r == sysctl_pkg::IDX_START3)
      |=> ##1 MASTER_START_ADDR[31:24] == $past(IO_WDATA, 2))
      else $error("start address byte not applied");

   unlock_c: cover property (IO_WR && IO_ADDR == sysctl_pkg::LOCK_PORT
      ##1 unlock_r);
   status_rd_c: cover property (IO_RD && unlock_r &&
      IO_ADDR == sysctl_pkg::DATA_PORT && index_r == sysctl_pkg::IDX_STATUS);
   irq_c: cover property (IRQ);
   burst_c: cover property (BURST_READ_EN);
endmodule : system_control_register_bank

// ==== verif/io_host_model.sv ====
// host-side i/o master for the indexed register ports
`timescale 1ns/1ps
module io_host_model (
   input wire logic CLK,
   output logic [15:0] IO_ADDR,
   output logic IO_WR,
   output logic IO_RD,
   output logic [7:0] IO_WDATA,
   input wire logic [7:0] IO_RDATA,
   input wire logic IO_RVALID
);
   initial begin
      IO_ADDR = 16'h0000;
      IO_WR = 1'b0;
      IO_RD = 1'b0;
      IO_WDATA = 8'h00;
   end
   // released lines carry the inverse so stale values never match
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CLK);
      IO_ADDR <= a;
      IO_WDATA <= d;
      IO_WR <= 1'b1;
      @(posedge CLK);
      IO_WR <= 1'b0;
      IO_ADDR <= ~a;
      IO_WDATA <= ~d;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d,
                     output logic ok);
      @(posedge CLK);
      IO_ADDR <= a;
      IO_RD <= 1'b1;
      @(posedge CLK);
      IO_RD <= 1'b0;
      IO_ADDR <= ~a;
      @(posedge CLK);
      ok = IO_RVALID;
      d = IO_RDATA;
   endtask : rd
   task automatic unlock(input logic [4:0] low);
      wr(sysctl_pkg::LOCK_PORT, {sysctl_pkg::UNLOCK_KEY, low});
   endtask : unlock
endmodule : io_host_model

// ==== verif/system_control_register_bank_bench.sv ====
// self-checking bench for the system control register bank
`timescale 1ns/1ps
module system_control_register_bank_bench;
   logic CLK = 1'b0, RSTN = 1'b0, IO_WR, IO_RD, IO_RVALID;
   logic [15:0] IO_ADDR;
   logic [7:0] IO_WDATA, IO_RDATA;
   logic [2:0] FRAME_STATUS = 3'h0;
   logic [3:0] ENGINE_FIFO_USED = 4'h0, IRQ_SOURCES = 4'h0;
   logic ENGINE_BUSY = 1'b0, CLKRUN_N_IN = 1'b1;
   logic [19:0] HOST_MEM_ADDR = 20'hA0000;
   logic [1:0] GFX_MEM_MAP = 2'h0, ZBUF_HALF_EN;
   logic [31:0] MASTER_START_ADDR;
   logic INDICATOR_A_OE, CLKRUN_REQ, BI_ENDIAN, BURST_READ_EN;
   logic SOFT_ABORT_EN, HOST_MEM_BLOCK, ENDIAN_SWAP_MODE, MMIO_EN;
   logic LEGACY_HIT, WRAP_256K, BUS_64BIT, IRQ;
   logic INDICATOR_A_OUT, BURST_EN, ENGINE_ABORT_EN, SUBSYS_ID_LOCK, LINEAR_EN;
   logic LATENCY_TIMER_DISABLE, ROTATE_BLT_EN;
   logic [7:0] m [256];
   int miscompares = 0, num_checks = 0;
   logic [31:0] seed = 32'h5393;
   initial forever #4 CLK = ~CLK;
   io_host_model host (.CLK(CLK), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
      .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
      .IO_RVALID(IO_RVALID));
   system_control_register_bank dut (.CLK(CLK), .RSTN(RSTN),
      .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
      .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID),
      .FRAME_STATUS(FRAME_STATUS), .ENGINE_FIFO_USED(ENGINE_FIFO_USED),
      .ENGINE_BUSY(ENGINE_BUSY), .IRQ_SOURCES(IRQ_SOURCES),
      .HOST_MEM_ADDR(HOST_MEM_ADDR), .GFX_MEM_MAP(GFX_MEM_MAP),
      .CLKRUN_N_IN(CLKRUN_N_IN), .INDICATOR_A_OUT(INDICATOR_A_OUT),
      .INDICATOR_A_OE(INDICATOR_A_OE),
      .CLKRUN_REQ(CLKRUN_REQ), .MASTER_START_ADDR(MASTER_START_ADDR),
      .BI_ENDIAN(BI_ENDIAN), .BURST_READ_EN(BURST_READ_EN),
      .BURST_EN(BURST_EN), .ENGINE_ABORT_EN(ENGINE_ABORT_EN),
      .SOFT_ABORT_EN(SOFT_ABORT_EN),
      .SUBSYS_ID_LOCK(SUBSYS_ID_LOCK), .HOST_MEM_BLOCK(HOST_MEM_BLOCK),
      .ENDIAN_SWAP_MODE(ENDIAN_SWAP_MODE), .ZBUF_HALF_EN(ZBUF_HALF_EN),
      .MMIO_EN(MMIO_EN), .LATENCY_TIMER_DISABLE(LATENCY_TIMER_DISABLE),
      .LINEAR_EN(LINEAR_EN),
      .LEGACY_HIT(LEGACY_HIT), .WRAP_256K(WRAP_256K),
      .BUS_64BIT(BUS_64BIT), .ROTATE_BLT_EN(ROTATE_BLT_EN), .IRQ(IRQ));
   // ----------------------------------------
   // reference model
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [7:0] wm(logic [7:0] i);
      case (i)
         8'h10, 8'h11, 8'h12, 8'h13, 8'h18: return 8'hFF;
         8'h15: return sysctl_pkg::WM_MISC;
         8'h17: return sysctl_pkg::WM_CMD1;
         8'h19: return sysctl_pkg::WM_IRQEM;
         default: return 8'h00;
      endcase
   endfunction : wm
   function automatic logic leg(logic [19:0] a, logic [1:0] mp);
      if (m[8'h18][0]) return !m[8'h18][5] && a <= 20'hAFFFF;
      case (mp)
         2'h0: return 1'b1;
         2'h1: return a <= 20'hAFFFF;
         2'h2: return a >= 20'hB0000 && a <= 20'hB7000;
         default: return a >= 20'hB8000;
      endcase
   endfunction : leg
   // ----------------------------------------
   // checks and bus helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] i, input logic [7:0] v);
      host.wr(sysctl_pkg::INDEX_PORT, i);
      host.wr(sysctl_pkg::DATA_PORT, v);
      m[i] = v & wm(i);
   endtask : wreg
   task automatic rchk(input logic [7:0] i, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      host.wr(sysctl_pkg::INDEX_PORT, i);
      host.rd(sysctl_pkg::DATA_PORT, d, ok);
      chk(ok, 1);
      chk(d, e);
   endtask : rchk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   initial begin
      #400000;
      miscompares++;
      end_of_test();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      logic [7:0] d, st;
      logic ok;
      logic [1:0] z;
      for (int i = 0; i < 256; i++) m[i] = 8'h00;
      repeat (12) @(posedge CLK);
      RSTN <= 1'b1;
      chk(ZBUF_HALF_EN, 3);
      chk(WRAP_256K, 1);
      host.wr(sysctl_pkg::INDEX_PORT, 8'h17);
      host.wr(sysctl_pkg::DATA_PORT, 8'hFF);
      for (int i = 16; i < 27; i++) rchk(8'(i), 8'h00);
      $display("test locked done");
      host.unlock(5'(rnd()));
      host.rd(sysctl_pkg::LOCK_PORT, d, ok);
      chk(d, 8'h40);
      rchk(8'h17, 8'h00);
      for (int n = 0; n < 40; n++) begin
         r = rnd();
         @(posedge CLK);
         FRAME_STATUS <= r[2:0];
         ENGINE_BUSY <= r[3];
         IRQ_SOURCES <= r[7:4];
         GFX_MEM_MAP <= r[9:8];
         CLKRUN_N_IN <= r[10];
         ENGINE_FIFO_USED <= 4'(r[15:12] % 9);
         HOST_MEM_ADDR <= 20'hA0000 + 20'(r[31:15]);
         // aperture byte goes before linear mode byte
         for (int i = 16; i < 26; i++) wreg(8'(i), 8'(rnd()));
         repeat (5) @(posedge CLK);
         for (int i = 16; i < 26; i++)
            if (i != 22) rchk(8'(i), m[i]);
         st[7:5] = r[2:0];
         st[4] = (r[15:12] % 9) != 0;
         st[3] = r[3];
         st[2:0] = ((r[15:12] % 9) inside {0, 8}) ? 3'h7
                   : 3'(7 - r[15:12] % 9);
         rchk(8'h16, st);
         rchk(8'h1A, {3'h0, r[7], 1'b0, r[6:4]});
         chk(MASTER_START_ADDR, {m[19], m[18], m[17], m[16][7:1], 1'b0});
         chk(BI_ENDIAN, m[16][0]);
         chk(BURST_READ_EN, m[8'h15][7] & m[8'h17][5]);
         chk(SOFT_ABORT_EN, m[8'h15][5] & m[8'h15][4]);
         chk(HOST_MEM_BLOCK, m[8'h17][7] & r[3]);
         chk(ENDIAN_SWAP_MODE, m[8'h17][4]);
         z = m[8'h17][3:2];
         chk(ZBUF_HALF_EN, z == 2'h1 ? 1 : z == 2'h2 ? 2 : 3);
         chk(MMIO_EN, m[8'h17][1] & m[8'h18][0]);
         chk(INDICATOR_A_OE, m[8'h18][7]);
         chk(CLKRUN_REQ, m[8'h18][6] & ~m[8'h18][7] & ~r[10]);
         chk(LEGACY_HIT, leg(20'hA0000 + 20'(r[31:15]), r[9:8]));
         chk(WRAP_256K, m[8'h18][4:3] == 2'h0);
         chk(BUS_64BIT, m[8'h18][4] | m[8'h18][2]);
         chk(IRQ, |(r[6:4] & m[8'h19][6:4] & ~m[8'h19][2:0]));
         chk(INDICATOR_A_OUT, r[3]);
         chk(BURST_EN, m[8'h17][5]);
         chk(ENGINE_ABORT_EN, m[8'h15][4]);
         chk(SUBSYS_ID_LOCK, m[8'h15][3]);
         chk(LATENCY_TIMER_DISABLE, m[8'h17][0]);
         chk(LINEAR_EN, m[8'h18][0]);
         chk(ROTATE_BLT_EN, m[8'h18][1]);
      end
      $display("test random access done");
      host.wr(sysctl_pkg::LOCK_PORT, 8'h00);
      rchk(8'h17, 8'h00);
      $display("test relock done");
      RSTN <= 1'b0;
      repeat (3) @(posedge CLK);
      RSTN <= 1'b1;
      @(posedge CLK);
      chk(ZBUF_HALF_EN, 3);
      chk(WRAP_256K, 1);
      host.unlock(5'h00);
      rchk(8'h18, 8'h00);
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule : system_control_register_bank_bench
